// file: dv/sfc_cmd_chk.sv
`timescale 1ns/1ns
module sfc_cmd_chk (
    // clock and reset
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    // observed ports
    input wire logic        cs_n_i,
    input wire logic        err_2bit_i,
    input wire logic        err_1bit_i,
    input wire logic [23:0] err_unit_i,
    input wire logic        write_latch_clr_o,
    input wire logic        refresh_fix_o,
    input wire logic [7:0]  check_status_byte_o,
    input wire logic [31:0] fault_address_trap_o,
    input wire logic [15:0] double_bit_counter_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    fix_echo_a: assert property (err_1bit_i |=> refresh_fix_o)
        else $error("refresh fix missing after single-bit event");
    fix_quiet_a: assert property (!err_1bit_i |=> !refresh_fix_o)
        else $error("refresh fix without single-bit event");
    single_silent_a: assert property (err_1bit_i && !err_2bit_i && !check_status_byte_o[4]
        |=> !check_status_byte_o[4])
        else $error("single-bit event was reported");
    flag_set_a: assert property (err_2bit_i |=> check_status_byte_o[4])
        else $error("double-bit flag not set");
    rsvd_zero_a: assert property (check_status_byte_o[7:5] == 3'h0
        && check_status_byte_o[3:0] == 4'h0)
        else $error("reserved status bits not zero");
    trap_top_a: assert property (fault_address_trap_o[31:24] == 8'h00)
        else $error("trap top byte not zero");
    trap_first_a: assert property (err_2bit_i && !check_status_byte_o[4]
        |=> fault_address_trap_o == {8'h00, $past(err_unit_i)})
        else $error("first fault unit not trapped");
    trap_hold_a: assert property ($past(check_status_byte_o[4]) && check_status_byte_o[4]
        |-> $stable(fault_address_trap_o))
        else $error("trap overwritten by later fault");
    count_inc_a: assert property (err_2bit_i && double_bit_counter_o != 16'hffff
        |=> double_bit_counter_o == $past(double_bit_counter_o) + 16'h0001)
        else $error("counter did not add one");
    count_sat_a: assert property (err_2bit_i && double_bit_counter_o == 16'hffff
        |=> double_bit_counter_o == 16'hffff)
        else $error("counter left its maximum");
    latch_clr_a: assert property (write_latch_clr_o |-> cs_n_i ##1 !write_latch_clr_o)
        else $error("latch clear not a single pulse after select rise");

    cover property (err_2bit_i ##1 check_status_byte_o[4]);
    cover property (write_latch_clr_o);
    cover property (err_2bit_i && double_bit_counter_o == 16'hffff);
endmodule

bind sfc_cmd sfc_cmd_chk u_chk (
    .sys_clk_i, .rst_n_i, .cs_n_i, .err_2bit_i, .err_1bit_i, .err_unit_i,
    .write_latch_clr_o, .refresh_fix_o, .check_status_byte_o, .fault_address_trap_o,
    .double_bit_counter_o
);

// file: dv/sfc_cmd_tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
module sfc_cmd_tb;
    typedef struct {
        int         ln;
        logic [3:0] lat;
        logic [7:0] a;
        logic [7:0] d;
        logic       write_latch_bit;
    } sfc_row_t;
    logic        sys_clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        sck, cs_n, write_latch_bit, e2, e1, clr, fix, four, two;
    logic [3:0]  lat, d_io, d_oe, h_io, lanes;
    logic [23:0] a_addr, eu;
    logic [20:0] q_unit;
    logic [7:0]  st, rd;
    logic [31:0] trap;
    logic [15:0] cnt;
    logic [7:0]  sec [256];
    int          failures, check_count, cycles, clr_count, exp_clr;
    sfc_row_t    rows [4] = '{'{1, 4'h0, 8'h10, 8'h5a, 1'b1}, '{2, 4'h3, 8'h20, 8'ha3, 1'b1},
                              '{4, 4'hf, 8'hfe, 8'h3c, 1'b1}, '{4, 4'h2, 8'h10, 8'hff, 1'b0}};

    assign lanes = (d_oe & d_io) | (~d_oe & h_io);
    always #5 sys_clk_i = ~sys_clk_i;

    sfc_cmd dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sck_i(sck), .cs_n_i(cs_n), .io_i(lanes),
        .io_o(d_io), .io_oe_o(d_oe), .latency_code_i(lat), .four_lane_cmd_mode_i(four),
        .two_lane_cmd_mode_i(two), .write_latch_bit_i(write_latch_bit), .write_latch_clr_o(clr),
        .array_addr_o(a_addr), .array_data_i(a_addr[7:0] ^ 8'h33), .query_unit_o(q_unit),
        .unit_err_i(q_unit == 21'h000123), .err_2bit_i(e2), .err_1bit_i(e1),
        .err_unit_i(eu), .refresh_fix_o(fix), .check_status_byte_o(st),
        .fault_address_trap_o(trap), .double_bit_counter_o(cnt));
    sfc_host host (.sck_o(sck), .cs_n_o(cs_n), .io_o(h_io), .io_i(lanes));

    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic pulse2(input logic [23:0] u);
        @(negedge sys_clk_i);
        e2 = 1'b1;
        eu = u;
        @(negedge sys_clk_i);
        e2 = 1'b0;
    endtask

    // the latch bit lives outside the block, so the bench keeps it
    always @(posedge sys_clk_i) begin
        cycles++;
        if (clr === 1'b1) begin
            clr_count++;
            write_latch_bit <= 1'b0;
        end
        if (cycles == 90000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        {write_latch_bit, e2, e1, four, two} = 5'h00;
        lat = 4'h0;
        eu = 24'h000000;
        repeat (4) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        `CHK(st, 8'h00)
        `CHK(trap, 32'h00000000)
        `CHK(cnt, 16'h0000)
        foreach (rows[i]) begin
            @(negedge sys_clk_i);
            lat = rows[i].lat;
            two = (rows[i].ln == 2);
            four = (rows[i].ln == 4);
            write_latch_bit = rows[i].write_latch_bit;
            // mode, latency and latch bit need two link edges to pass their syncs
            repeat (2) host.clk1();
            host.head(rows[i].ln, 8'h42, {16'h0000, rows[i].a}, 0);
            host.send(rows[i].ln, rows[i].d);
            host.send(rows[i].ln, ~rows[i].d);
            host.close();
            if (rows[i].write_latch_bit) begin
                sec[rows[i].a] = rows[i].d;
                sec[rows[i].a + 8'h01] = ~rows[i].d;
                exp_clr++;
            end
            `CHK(clr_count, exp_clr)
            `CHK(write_latch_bit, 1'b0)
            host.head(rows[i].ln, 8'h4b, {16'h0000, rows[i].a}, rows[i].lat);
            host.recv(rows[i].ln, rd);
            `CHK(rd, sec[rows[i].a])
            host.recv(rows[i].ln, rd);
            `CHK(rd, sec[rows[i].a + 8'h01])
            host.close();
        end
        @(negedge sys_clk_i);
        lat = 4'h3;
        repeat (2) host.clk1();
        host.ddr_read(1'b1, 32'h000040a5, 3, rd);
        `CHK(rd, 8'h73)
        host.close();
        host.ddr_read(1'b0, 32'h00008100, 3, rd);
        `CHK(rd, 8'hb2)
        `CHK(d_oe, 4'hf)
        host.close();
        host.ddr_read(1'b0, 32'h00000500, 3, rd);
        `CHK(d_oe, 4'h0)
        host.close();
        @(negedge sys_clk_i);
        {four, two} = 2'h0;
        // unit status needs three dummies to clear its sync pair
        repeat (2) host.clk1();
        host.head(1, 8'h19, 24'h00091f, 3);
        host.recv(1, rd);
        `CHK(rd, 8'h10)
        host.close();
        host.head(1, 8'h19, 24'h000920, 3);
        host.recv(1, rd);
        `CHK(rd, 8'h00)
        host.close();
        pulse2(24'h000918);
        pulse2(24'h000a00);
        @(negedge sys_clk_i);
        `CHK(st, 8'h10)
        `CHK(trap, 32'h00000918)
        `CHK(cnt, 16'h0002)
        e1 = 1'b1;
        @(negedge sys_clk_i);
        e1 = 1'b0;
        `CHK(fix, 1'b1)
        `CHK(st, 8'h10)
        host.open();
        host.send(1, 8'h1b);
        host.close();
        @(negedge sys_clk_i);
        `CHK({st, trap, cnt}, 56'h0)
        e2 = 1'b1;
        eu = 24'h000008;
        repeat (65535) @(negedge sys_clk_i);
        `CHK(cnt, 16'hffff)
        @(negedge sys_clk_i);
        e2 = 1'b0;
        `CHK(cnt, 16'hffff)
        `CHK(trap, 32'h00000008)
        rst_n_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        `CHK({st, trap, cnt}, 56'h0)
        end_of_test();
    end
endmodule

// file: dv/sfc_host.sv
`timescale 1ns/1ns
module sfc_host (
    // link lines toward the device
    output logic            sck_o,
    output logic            cs_n_o,
    output logic      [3:0] io_o,
    // resolved lane levels
    input  wire logic [3:0] io_i
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        io_o = 4'h5;
    end
    // clock stands low between frames, so only the tasks move it
    task automatic clk1();
        #62 sck_o = 1'b1;
        #63 sck_o = 1'b0;
    endtask
    task automatic open();
        #20 cs_n_o = 1'b0;
    endtask
    // bits per cycle follow the lane count of the mode
    task automatic send(input int ln, input logic [7:0] b);
        logic [11:0] w;
        w = {4'h0, b};
        for (int i = 8 - ln; i >= 0; i -= ln) begin
            io_o = w[i +: 4];
            clk1();
        end
    endtask
    task automatic recv(input int ln, output logic [7:0] b);
        b = 8'h00;
        for (int i = 0; i < 8 / ln; i++) begin
            #62 sck_o = 1'b1;
            b = (b << ln) | ((ln == 1) ? {7'h00, io_i[1]} : {4'h0, io_i & 4'((1 << ln) - 1)});
            #63 sck_o = 1'b0;
        end
    endtask
    task automatic head(input int ln, input logic [7:0] op, input logic [23:0] a, input int dum);
        open();
        send(ln, op);
        send(ln, a[23:16]);
        send(ln, a[15:8]);
        send(ln, a[7:0]);
        repeat (dum) clk1();
    endtask
    // the long gap lets the system side see the frame end
    task automatic close();
        #62 cs_n_o = 1'b1;
        io_o = ~io_o; // released lanes never keep the last bit
        #400;
    endtask
    // dual-edge read of one byte; am is address then mode, opcode left out when op is 0
    task automatic ddr_read(input bit op, input logic [31:0] am, input int dum,
                            output logic [7:0] b);
        open();
        if (op) send(4, 8'hed);
        for (int i = 24; i >= 0; i -= 8) begin
            #20 io_o = am[i + 4 +: 4];
            #42 sck_o = 1'b1;
            #31 io_o = am[i +: 4];
            #32 sck_o = 1'b0;
        end
        repeat (dum) clk1();
        #31 b[7:4] = io_i;
        #31 sck_o = 1'b1;
        #31 b[3:0] = io_i;
        #32 sck_o = 1'b0;
    endtask
endmodule

// file: rtl/sfc_cmd.sv
`timescale 1ns/1ns
`include "sfc_regs.svh"
module sfc_cmd
    import sfc_pkg::*;
(
    // system clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // serial link
    input  wire logic        sck_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  io_i,
    output logic      [3:0]  io_o,
    output logic      [3:0]  io_oe_o,
    // configuration and status bits held elsewhere
    input  wire logic [3:0]  latency_code_i,
    input  wire logic        four_lane_cmd_mode_i,
    input  wire logic        two_lane_cmd_mode_i,
    input  wire logic        write_latch_bit_i,
    output logic             write_latch_clr_o,
    // main array side
    output logic      [23:0] array_addr_o,
    input  wire logic [7:0]  array_data_i,
    output logic      [20:0] query_unit_o,
    input  wire logic        unit_err_i,
    input  wire logic        err_2bit_i,
    input  wire logic        err_1bit_i,
    input  wire logic [23:0] err_unit_i,
    output logic             refresh_fix_o,
    // check state, read through the any-register read path
    output logic      [7:0]  check_status_byte_o,
    output logic      [31:0] fault_address_trap_o,
    output logic      [15:0] double_bit_counter_o
);

    sfc_frame_t lk;
    sfc_frame_t next_lk;
    sfc_keep_t  ps;
    sfc_keep_t  next_ps;
    sfc_fall_t  ng;
    sfc_fall_t  next_ng;
    sfc_sys_t   sy;
    sfc_sys_t   next_sy;

    logic [7:0] sector [256];
    logic       sec_we;
    logic [7:0] sec_wa;
    logic [7:0] sec_wd;
    logic [3:0] neg_in;
    logic       frame_rst_n;

    // select high ends the frame on its own, the link clock may stop at any time
    assign frame_rst_n = rst_n_i & ~cs_n_i;

    always_comb begin
        logic [3:0] w;
        logic [7:0] shin;
        logic [7:0] dbyte;
        logic       done;
        logic       load;
        w       = 4'd1;
        shin    = 8'h00;
        done    = 1'b0;
        next_lk = lk;
        next_ps = ps;
        sec_we  = 1'b0;
        sec_wa  = lk.addr[7:0];
        sec_wd  = lk.sh;
        load    = 1'b0;
        dbyte   = {lk.hi, neg_in};
        next_ps.lat_m  = latency_code_i;
        next_ps.lat_s  = ps.lat_m;
        next_ps.quad_m = four_lane_cmd_mode_i;
        next_ps.quad_s = ps.quad_m;
        next_ps.dual_m = two_lane_cmd_mode_i;
        next_ps.dual_s = ps.dual_m;
        next_ps.wel_m  = write_latch_bit_i;
        next_ps.wel_s  = ps.wel_m;
        next_ps.uerr_m = unit_err_i;
        next_ps.uerr_s = ps.uerr_m;
        next_ps.ad_m   = array_data_i;
        next_ps.ad_s   = ps.ad_m;
        if (ps.quad_s) begin
            w    = 4'd4;
            shin = {lk.sh[3:0], io_i}; // R6
        end else if (ps.dual_s) begin
            w    = 4'd2;
            shin = {lk.sh[5:0], io_i[1:0]};
        end else begin
            w    = 4'd1;
            shin = {lk.sh[6:0], io_i[0]};
        end
        done = (lk.bitcnt + w) == 4'd8;
        next_lk.run = 1'b1;
        if (!lk.run) begin
            // flags of the previous frame were taken over at its select rise
            next_ps.wt_pend = 1'b0;
            next_ps.cl_pend = 1'b0;
        end
        if (!lk.run && ps.continuous_read_mode && ps.quad_s) begin
            next_lk.cmd   = CM_DDRRD; // R2
            next_lk.phase = PH_ADDR;
            next_lk.hi    = io_i;
        end else if (lk.cmd == CM_DDRRD && lk.phase != PH_OPC) begin
            // one byte per link cycle, rising nibble first; R1
            next_lk.hi    = io_i;
            next_lk.prime = 1'b0;
            if (!lk.prime) begin
                case (lk.phase)
                    PH_ADDR: begin
                        next_lk.addr    = {lk.addr[15:0], dbyte};
                        next_lk.bytecnt = lk.bytecnt + 2'd1;
                        if (lk.bytecnt == `SFC_ADDR_LAST) begin
                            next_lk.phase = PH_MODE;
                        end
                    end
                    PH_MODE: begin
                        next_ps.continuous_read_mode = (dbyte == `SFC_XIP_MODE); // R2
                        if (ps.lat_s <= 4'd1) begin
                            load = 1'b1;
                        end else begin
                            next_lk.phase = PH_DUMMY;
                            next_lk.dcnt  = ps.lat_s - 4'd1; // R3
                        end
                    end
                    PH_DUMMY: begin
                        next_lk.dcnt = lk.dcnt - 4'd1;
                        if (lk.dcnt == 4'd1) begin
                            load = 1'b1;
                        end
                    end
                    PH_RDATA: begin
                        next_lk.out_p = lk.tx[3:0] ^ ng.out_n;
                        next_lk.addr  = lk.addr + 24'd1;
                        load          = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end else begin
            case (lk.phase)
                PH_OPC: begin
                    next_lk.sh     = shin;
                    next_lk.bitcnt = done ? 4'd0 : lk.bitcnt + w;
                    if (done) begin
                        next_lk.phase   = PH_ADDR;
                        next_lk.bytecnt = 2'd0;
                        case (shin)
                            `SFC_OP_SECW: begin
                                if (ps.wel_s) begin // R11
                                    next_lk.cmd     = CM_SECW; // R5
                                    next_ps.wt_pend = 1'b1; // R12
                                end else begin
                                    next_lk.phase = PH_SKIP;
                                end
                            end
                            `SFC_OP_SECR: begin
                                next_lk.cmd = CM_SECR; // R4
                            end
                            `SFC_OP_QUERY: begin
                                next_lk.cmd = CM_QUERY; // R20
                            end
                            `SFC_OP_CLEAR: begin
                                next_ps.cl_pend = 1'b1; // R24
                                next_lk.phase   = PH_SKIP;
                            end
                            `SFC_OP_DDRRD: begin
                                if (ps.quad_s) begin // R1
                                    next_lk.cmd   = CM_DDRRD;
                                    next_lk.prime = 1'b1;
                                end else begin
                                    next_lk.phase = PH_SKIP;
                                end
                            end
                            default: begin
                                next_lk.phase = PH_SKIP;
                            end
                        endcase
                    end
                end
                PH_ADDR: begin
                    next_lk.sh     = shin;
                    next_lk.bitcnt = done ? 4'd0 : lk.bitcnt + w;
                    if (done) begin
                        next_lk.addr    = {lk.addr[15:0], shin};
                        next_lk.bytecnt = lk.bytecnt + 2'd1;
                        if (lk.bytecnt == `SFC_ADDR_LAST) begin
                            if (lk.cmd == CM_SECW) begin
                                next_lk.phase = PH_WDATA; // R5
                            end else if (ps.lat_s == 4'd0) begin
                                load = 1'b1;
                            end else begin
                                next_lk.phase = PH_DUMMY;
                                next_lk.dcnt  = ps.lat_s; // R3 R25
                            end
                        end
                    end
                end
                PH_DUMMY: begin
                    next_lk.dcnt = lk.dcnt - 4'd1;
                    if (lk.dcnt == 4'd1) begin
                        load = 1'b1;
                    end
                end
                PH_WDATA: begin
                    next_lk.sh     = shin; // R9
                    next_lk.bitcnt = done ? 4'd0 : lk.bitcnt + w;
                    if (done) begin
                        // sector bypasses the error check entirely; R21
                        sec_we = 1'b1;
                        sec_wd = shin;
                        sec_wa = lk.addr[7:0]; // R10
                        next_lk.addr[7:0] = lk.addr[7:0] + 8'd1; // R7
                        if (lk.addr[7:0] == `SFC_SEC_TOP) begin
                            // no wrap onto byte zero if the host keeps clocking; R8
                            next_lk.phase = PH_SKIP;
                        end
                    end
                end
                PH_RDATA: begin
                    next_lk.bitcnt = done ? 4'd0 : lk.bitcnt + w;
                    next_lk.tx     = lk.tx << w;
                    if (done) begin
                        next_lk.addr = lk.addr + 24'd1; // R13
                        load         = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (load) begin
            next_lk.phase = PH_RDATA;
            case (next_lk.cmd)
                CM_SECR: begin
                    // the index wraps past the top, so later bytes mean nothing; R14
                    next_lk.tx = sector[next_lk.addr[7:0]];
                end
                CM_QUERY: begin
                    // unit status comes through a sync pair: needs three dummies or more
                    next_lk.tx = 8'h00; // R22
                    if (lk.phase != PH_RDATA) begin
                        next_lk.tx[`SFC_QRY_BIT] = ps.uerr_s; // R25
                    end
                end
                default: begin
                    // array data trails the address by the sync pair; a known limitation
                    next_lk.tx = ps.ad_s;
                end
            endcase
        end
    end

    always_comb begin
        next_ng = ng;
        next_ng.oe    = 4'h0;
        next_ng.out_n = 4'h0;
        if (lk.phase == PH_RDATA) begin
            if (lk.cmd == CM_DDRRD) begin
                next_ng.out_n = lk.tx[7:4] ^ lk.out_p;
                next_ng.oe    = 4'hf;
            end else if (ps.quad_s) begin
                next_ng.out_n = lk.tx[7:4];
                next_ng.oe    = 4'hf;
            end else if (ps.dual_s) begin
                next_ng.out_n = {2'b00, lk.tx[7:6]};
                next_ng.oe    = 4'h3;
            end else begin
                next_ng.out_n = {2'b00, lk.tx[7], 1'b0};
                next_ng.oe    = 4'h2;
            end
        end
    end

    always_comb begin
        logic end_frame;
        end_frame       = sy.cs_s & ~sy.cs_d;
        next_sy         = sy;
        next_sy.cs_m    = cs_n_i;
        next_sy.cs_s    = sy.cs_m;
        next_sy.cs_d    = sy.cs_s;
        next_sy.wt_m    = ps.wt_pend;
        next_sy.wt_s    = sy.wt_m;
        next_sy.cl_m    = ps.cl_pend;
        next_sy.cl_s    = sy.cl_m;
        next_sy.wel_clr = end_frame & sy.wt_s; // R12
        next_sy.fix     = err_1bit_i; // R16
        if (end_frame && sy.cl_s) begin
            next_sy.status   = `SFC_STATUS_RST; // R24
            next_sy.trap     = 32'h0000_0000;
            next_sy.trap_vld = 1'b0;
            next_sy.count    = 16'h0000;
        end
        // an error in the clearing cycle survives the clear
        if (err_2bit_i) begin // R15
            next_sy.status[`SFC_FLAG_BIT] = 1'b1; // R17 R22
            if (!next_sy.trap_vld) begin
                next_sy.trap     = {8'h00, err_unit_i}; // R18 R26
                next_sy.trap_vld = 1'b1;
            end
            if (next_sy.count != `SFC_CNT_MAX) begin // R23
                next_sy.count = next_sy.count + 16'd1; // R19
            end
        end
    end

    always_ff @(posedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    always_ff @(posedge sck_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ps <= '0;
        end else begin
            ps <= next_ps;
        end
    end

    always_ff @(posedge sck_i) begin
        if (sec_we) begin
            sector[sec_wa] <= sec_wd;
        end
    end

    // falling edge launches single-rate data and the rising nibble of dual-edge data
    always_ff @(negedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            ng     <= '0;
            neg_in <= 4'h0;
        end else begin
            ng     <= next_ng;
            neg_in <= io_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sy      <= '0;
            sy.cs_m <= 1'b1;
            sy.cs_s <= 1'b1;
            sy.cs_d <= 1'b1;
        end else begin
            sy <= next_sy;
        end
    end

    // the xor pair lets both edges steer the lanes without a clock-gated mux
    assign io_o                 = ng.out_n ^ lk.out_p;
    assign io_oe_o              = ng.oe;
    assign write_latch_clr_o    = sy.wel_clr;
    assign refresh_fix_o        = sy.fix;
    assign check_status_byte_o  = sy.status;
    assign fault_address_trap_o = sy.trap;
    assign double_bit_counter_o = sy.count;
    assign array_addr_o         = lk.addr;
    assign query_unit_o         = lk.addr[23:3];

endmodule

// file: rtl/sfc_pkg.sv
package sfc_pkg;

    typedef enum logic [2:0] {
        PH_OPC   = 3'b000,
        PH_ADDR  = 3'b001,
        PH_MODE  = 3'b010,
        PH_DUMMY = 3'b011,
        PH_WDATA = 3'b100,
        PH_RDATA = 3'b101,
        PH_SKIP  = 3'b110
    } sfc_phase_t;

    typedef enum logic [2:0] {
        CM_NONE  = 3'b000,
        CM_SECW  = 3'b001,
        CM_SECR  = 3'b010,
        CM_QUERY = 3'b011,
        CM_DDRRD = 3'b100
    } sfc_cmd_t;

    // frame state, cleared while select is high
    typedef struct packed {
        logic        run;
        sfc_phase_t  phase;
        sfc_cmd_t    cmd;
        logic [3:0]  bitcnt;
        logic [1:0]  bytecnt;
        logic [3:0]  dcnt;
        logic        prime;
        logic [7:0]  sh;
        logic [7:0]  tx;
        logic [23:0] addr;
        logic [3:0]  hi;
        logic [3:0]  out_p;
    } sfc_frame_t;

    // link-clock state that survives between frames
    typedef struct packed {
        logic [3:0] lat_m;
        logic [3:0] lat_s;
        logic       quad_m;
        logic       quad_s;
        logic       dual_m;
        logic       dual_s;
        logic       wel_m;
        logic       wel_s;
        logic       uerr_m;
        logic       uerr_s;
        logic [7:0] ad_m;
        logic [7:0] ad_s;
        logic       continuous_read_mode;
        logic       wt_pend;
        logic       cl_pend;
    } sfc_keep_t;

    typedef struct packed {
        logic [3:0] out_n;
        logic [3:0] oe;
    } sfc_fall_t;

    typedef struct packed {
        logic        cs_m;
        logic        cs_s;
        logic        cs_d;
        logic        wt_m;
        logic        wt_s;
        logic        cl_m;
        logic        cl_s;
        logic [7:0]  status;
        logic [31:0] trap;
        logic        trap_vld;
        logic [15:0] count;
        logic        wel_clr;
        logic        fix;
    } sfc_sys_t;

endpackage

// file: rtl/sfc_regs.svh
// What this block does
// R1: four-lane mode dual-edge read: opcode single-rate on four lanes, rest on both edges
// R2: continuation mode bits other than the A5 pattern end continuous read mode
// R3: dummy cycles before read data come from the four-bit latency code
// R4: separate 256-byte special sector reachable in one, two and four-lane modes
// R5: sector write opcode 42 without dummies, sector read opcode 4B with dummies
// R6: host sends write opcode and data on the lanes of the active mode
// R7: sector write address increments after each byte while select stays low
// R8: host raises select once the sector write counter reaches its top
// R9: sector write data is MSB first; select rising edge ends the write
// R10: host sends three address bytes; low byte selects, upper bytes zero
// R11: sector write executes only while the write latch bit is set
// R12: write latch bit is cleared when a sector write ends at select rise
// R13: sector read starts anywhere and auto-increments after each byte
// R14: sector read data past the top address is undefined
// R15: error check covers 8-byte units and reports double-bit errors
// R16: single-bit errors are corrected by the refresh and never reported
// R17: double-bit error sets status bit four; reset and clear command clear it
// R18: fault address trap keeps the first double-bit unit address only
// R19: two-byte counter adds one per double-bit error, cleared by reset
// R20: query command 19 returns double-bit status of the addressed unit
// R21: no error check on special sector, status or configuration registers
// R22: check status byte is volatile; all bits except four read zero
// R23: double-bit counter saturates at its maximum value
// R24: clear command 1B clears flag, trap and counter without write latch
// R25: query ignores three low address bits, inserts dummies, returns one byte
// R26: top byte of the fault address trap reads as zero
`ifndef SFC_REGS_SVH
`define SFC_REGS_SVH

`define SFC_OP_SECW     8'h42
`define SFC_OP_SECR     8'h4b
`define SFC_OP_QUERY    8'h19
`define SFC_OP_CLEAR    8'h1b
`define SFC_OP_DDRRD    8'hed
`define SFC_XIP_MODE    8'ha5
`define SFC_SEC_TOP     8'hff
`define SFC_CNT_MAX     16'hffff
`define SFC_STATUS_RST  8'h00
`define SFC_FLAG_BIT    4
`define SFC_QRY_BIT     4
`define SFC_ADDR_LAST   2'd2

`endif
